// *** tb/test_abort_routing_error_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_abort_routing_error_sync;
    import ares_pkg::*;
    // ==================================================
    // signals
    typedef struct packed {
        logic [1:0] lvl;
        logic [1:0] mode;
        logic [OFS_W-1:0] ofs;
        logic narrow;
    } ares_exp_s;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, reqValid = 1'b0, reqNarrow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0, reqKind = 2'h0, reqFromLevel = 2'h0;
    logic barrierExec = 1'b0, excEntry = 1'b0, debugLevelSwitch = 1'b0;
    logic excReturn = 1'b0, debugReturn = 1'b0, entryNarrow = 1'b0, returnNarrow = 1'b0;
    logic [1:0] entryLevel = 2'h0, returnLevel = 2'h0;
    logic errRaise = 1'b0, errSameCore = 1'b0;
    logic [7:0] errSyndrome = 8'h0, syn;
    wire hreadyout, hresp, routeValid, syncEvent, serrTake, intStatusAsync, deferredValid;
    wire [31:0] hrdata;
    wire [1:0] routeLevel, routeMode;
    wire [OFS_W-1:0] routeOffset;
    logic [13:0] ctrlV = 14'h0;
    logic [7:0] routeV = 8'h0;
    logic [31:0] readQ[$];
    ares_exp_s routeQ[$];
    ares_exp_s mon;
    logic rdPend = 1'b0;
    logic [1:0] k, f;
    logic n;
    int nFail = 0, nTests = 0, cycles = 0;
    // cfg word: ctrl, source, level, narrow, expected event
    localparam logic [31:0] SYNC_TAB [10] = '{32'h0220_1101, 32'h0200_1100,
        32'h0220_1200, 32'h0220_1110, 32'h1060_2301, 32'h1020_1300, 32'h0120_3001,
        32'h2060_4301, 32'h1060_3300, 32'h0000_0001};

    ares_abort_router DUT (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reqValid(reqValid),
        .reqKind(reqKind), .reqFromLevel(reqFromLevel), .reqNarrow(reqNarrow),
        .routeValid(routeValid), .routeLevel(routeLevel), .routeMode(routeMode),
        .routeOffset(routeOffset), .barrierExec(barrierExec), .excEntry(excEntry),
        .debugLevelSwitch(debugLevelSwitch), .entryLevel(entryLevel),
        .entryNarrow(entryNarrow), .excReturn(excReturn), .debugReturn(debugReturn),
        .returnLevel(returnLevel), .returnNarrow(returnNarrow), .errRaise(errRaise),
        .errSameCore(errSameCore), .errSyndrome(errSyndrome), .syncEvent(syncEvent),
        .serrTake(serrTake), .intStatusAsync(intStatusAsync), .deferredValid(deferredValid));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // ==================================================
    // helpers
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task testDone();
        $display("comparisons %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : testDone

    function automatic logic [31:0] addrOf(input logic [1:0] idx);
        return {28'h0, idx, 2'h0};
    endfunction : addrOf

    // reference routing: monitor first, then hypervisor, then default
    function automatic ares_exp_s expRoute(input logic [1:0] kind, input logic [1:0] from,
                                           input logic nar);
        ares_exp_s e;
        logic low, serr, hyp;
        low = (from <= LVL1);
        serr = (kind == ARES_ASYNC_SYSTEM_ERROR);
        e.narrow = nar;
        e.ofs = 5'h00;
        e.mode = ARES_MODE_ABORT;
        e.lvl = low ? LVL1 : from;
        if (!nar) begin
            hyp = ctrlV[CB_EL2_IMPL] && ctrlV[CB_EL2_ENABLED] && low && (routeV[RB_HYP_GENERAL]
                || (serr ? routeV[RB_HYP_ASYNC] : routeV[RB_HYP_EXT_ABORT]));
            if (ctrlV[CB_EL3_IMPL] && routeV[RB_MON_ROUTE]) e.lvl = LVL3;
            else if (hyp) e.lvl = LVL2;
        end else begin
            hyp = ctrlV[CB_EL2_IMPL] && ctrlV[CB_NON_SECURE] && low && (routeV[RB_NHYP_GENERAL]
                || (serr ? routeV[RB_NHYP_ASYNC] : routeV[RB_NHYP_ABORT]));
            e.ofs = (kind == ARES_PREFETCH_ABORT) ? OFS_PREFETCH : OFS_DATA;
            if (ctrlV[CB_EL3_IMPL] && routeV[RB_NMON_ROUTE]) begin
                e.lvl = LVL3;
                e.mode = ARES_MODE_MONITOR;
            end else if (hyp) begin
                e.lvl = LVL2;
                e.mode = ARES_MODE_HYP;
                e.ofs = OFS_HYP;
            end else if (from == LVL2) begin
                e.mode = ARES_MODE_HYP;
            end
        end
        return e;
    endfunction : expRoute

    // master never assumes a wait count, it polls hready
    task busXfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        if (!wr) readQ.push_back(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        if (wr && a == addrOf(IDX_CTRL)) ctrlV = d[13:0];
        if (wr && a == addrOf(IDX_ROUTE)) routeV = d[7:0];
        #1;
    endtask : busXfer

    task syncPulse(input logic [3:0] w, input logic [1:0] l, input logic nr, input logic e);
        @(posedge ref_clk);
        barrierExec <= (w == 4'h0);
        excEntry <= (w == 4'h1);
        debugLevelSwitch <= (w == 4'h2);
        excReturn <= (w == 4'h3);
        debugReturn <= (w == 4'h4);
        {entryLevel, returnLevel, entryNarrow, returnNarrow} <= {l, l, nr, nr};
        @(posedge ref_clk);
        {barrierExec, excEntry, debugLevelSwitch, excReturn, debugReturn} <= 5'h00;
        #1 check("syncEvent", {31'h0, syncEvent}, {31'h0, e});
    endtask : syncPulse

    task errPulse(input logic same);
        syn = 8'($urandom);
        @(posedge ref_clk);
        {errRaise, errSameCore, errSyndrome} <= {1'b1, same, syn};
        @(posedge ref_clk);
        errRaise <= 1'b0;
        #1 check("intStatusAsync", {31'h0, intStatusAsync}, 32'h1);
    endtask : errPulse

    task resetDut();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : resetDut
    // ==================================================
    // result watcher: takes the oldest note per result
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            testDone();
        end
        if (rdPend) check("hrdata", hrdata, readQ.pop_front());
        if (rdPend) check("hresp", {31'h0, hresp}, 32'h0);
        rdPend <= rst_n && hsel && htrans[1] && hreadyout && !hwrite;
        if (routeValid === 1'b1) begin
            mon = routeQ.pop_front();
            check("routeLevel", 32'(routeLevel), 32'(mon.lvl));
            check("routeOffset", 32'(routeOffset), 32'(mon.ofs));
            check("routeMode", 32'(routeMode), 32'(mon.mode));
        end
    end
    // ==================================================
    // main sequence
    initial begin
        void'($urandom(32'hEC39));
        resetDut();
        busXfer(addrOf(IDX_CTRL), 1'b0, 32'(CTRL_RESET));
        busXfer(addrOf(IDX_ROUTE), 1'b0, 32'(ROUTE_RESET));
        busXfer(32'h0000_0010, 1'b1, 32'hFFFF_FFFF);
        busXfer(32'h0000_0010, 1'b0, 32'h0);
        busXfer(addrOf(IDX_STAT), 1'b1, 32'hFFFF_FFFF);
        busXfer(addrOf(IDX_STAT), 1'b0, 32'h0);
        repeat (12) begin
            busXfer(addrOf(IDX_CTRL), 1'b1, {28'h0, 4'($urandom)});
            busXfer(addrOf(IDX_ROUTE), 1'b1, {24'h0, 8'($urandom)});
            busXfer(addrOf(IDX_ROUTE), 1'b0, {24'h0, routeV});
            repeat (10) begin
                k = 2'($urandom_range(2, 0));
                f = 2'($urandom);
                n = 1'($urandom);
                @(posedge ref_clk);
                {reqValid, reqKind, reqFromLevel, reqNarrow} <= {1'b1, k, f, n};
                routeQ.push_back(expRoute(k, f, n));
            end
            @(posedge ref_clk);
            reqValid <= 1'b0;
        end
        foreach (SYNC_TAB[i]) begin
            busXfer(addrOf(IDX_CTRL), 1'b1, {16'h0, SYNC_TAB[i][31:16]});
            syncPulse(SYNC_TAB[i][15:12], SYNC_TAB[i][9:8], SYNC_TAB[i][4], SYNC_TAB[i][0]);
        end
        // masked: barrier defers the error and clears it
        busXfer(addrOf(IDX_CTRL), 1'b1, 32'h0000_0010);
        errPulse(1'b1);
        syncPulse(4'h0, LVL1, 1'b0, 1'b1);
        check("deferredValid", {31'h0, deferredValid}, 32'h1);
        check("intStatusAsync", {31'h0, intStatusAsync}, 32'h0);
        check("serrTake", {31'h0, serrTake}, 32'h0);
        busXfer(addrOf(IDX_STAT), 1'b0, {19'h0, mon.ofs, mon.mode, mon.lvl, 4'h8});
        busXfer(addrOf(IDX_DEFER), 1'b0, {1'b1, 23'h0, syn});
        busXfer(addrOf(IDX_DEFER), 1'b1, 32'h8000_0000);
        check("deferredValid", {31'h0, deferredValid}, 32'h0);
        // unmasked: taken with the event
        busXfer(addrOf(IDX_CTRL), 1'b1, 32'h0000_0000);
        errPulse(1'b1);
        syncPulse(4'h0, LVL1, 1'b0, 1'b1);
        check("serrTake", {31'h0, serrTake}, 32'h1);
        check("deferredValid", {31'h0, deferredValid}, 32'h0);
        // foreign error is never synchronized, stays pending until reset
        busXfer(addrOf(IDX_CTRL), 1'b1, 32'h0000_0010);
        errPulse(1'b0);
        syncPulse(4'h0, LVL1, 1'b0, 1'b1);
        check("deferredValid", {31'h0, deferredValid}, 32'h0);
        check("intStatusAsync", {31'h0, intStatusAsync}, 32'h1);
        resetDut();
        #1 check("intStatusAsync", {31'h0, intStatusAsync}, 32'h0);
        busXfer(addrOf(IDX_CTRL), 1'b0, 32'(CTRL_RESET));
        repeat (3) @(posedge ref_clk);
        check("routeQueue", 32'(routeQ.size()), 32'h0);
        check("readQueue", 32'(readQ.size()), 32'h0);
        testDone();
    end
endmodule : test_abort_routing_error_sync
`default_nettype wire

// *** verilog/ares_abort_router.sv ***
// Summary of operation
// RL1: wide state, levels 0/1 route to level 1
// RL2: wide state, level 2/3 stay put
// RL3: monitor route bit sends everything to level 3
// RL4: hypervisor async/general bit routes errors to 2
// RL5: ext-abort/general trap bit routes aborts to 2
// RL6: narrow default: abort mode, hyp from 2
// RL7: narrow monitor route: errors/data aborts, offset 0x10
// RL8: narrow monitor route: prefetch aborts, offset 0x0C
// RL9: non-secure narrow: errors to hyp 0x14
// RL10: non-secure narrow: aborts to hyp 0x14
// RL11: barrier instruction always raises sync event
// RL12: wide entry with implicit sync raises event
// RL13: wide return with implicit sync raises event
// RL14: barrier records and clears masked pending error
// RL15: only same-core errors count as synchronized
// RL16: unmasked pending error taken before event completes
// RL17: masked, not pending: later errors are later
// RL18: not pending means status async bit reads 0
// RL19: masked barrier without valid keeps guarantees
// RL20: masked barrier: later error from later instruction
// RL21: masked pending: log, set valid, clear pending
// RL22: monitor first, then hypervisor, then default
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module ares_abort_router
    import ares_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register bus
    input wire logic hsel,
    input wire logic [ares_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [ares_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [ares_pkg::DATA_W-1:0] hrdata,
    // routing request
    input wire logic reqValid,
    input wire logic [1:0] reqKind,
    input wire logic [1:0] reqFromLevel,
    input wire logic reqNarrow,
    output logic routeValid,
    output logic [1:0] routeLevel,
    output logic [1:0] routeMode,
    output logic [ares_pkg::OFS_W-1:0] routeOffset,
    // synchronization sources
    input wire logic barrierExec,
    input wire logic excEntry,
    input wire logic debugLevelSwitch,
    input wire logic [1:0] entryLevel,
    input wire logic entryNarrow,
    input wire logic excReturn,
    input wire logic debugReturn,
    input wire logic [1:0] returnLevel,
    input wire logic returnNarrow,
    // error sources
    input wire logic errRaise,
    input wire logic errSameCore,
    input wire logic [ares_pkg::SYN_W-1:0] errSyndrome,
    // event and error results
    output logic syncEvent,
    output logic serrTake,
    output logic intStatusAsync,
    output logic deferredValid
);
    import ares_pkg::*;

    // ==================================================
    // state
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [ROUTE_W-1:0] route;
        logic dataPhase;
        logic dataWrite;
        logic dataMapped;
        logic [1:0] dataIdx;
        logic [DATA_W-1:0] rdata;
        logic routeValid;
        logic [1:0] routeLevel;
        ares_mode_e routeMode;
        logic [OFS_W-1:0] routeOffset;
        logic syncEvent;
        logic serrTake;
        logic syncPend;
        logic otherPend;
        logic [SYN_W-1:0] pendSyn;
        logic defValid;
        logic [SYN_W-1:0] defSyn;
    } ares_state_s;

    ares_state_s q;
    ares_state_s next_q;

    // ==================================================
    // helpers
    function automatic logic ares_low(input logic [1:0] lvl);
        ares_low = (lvl == LVL0) || (lvl == LVL1);
    endfunction : ares_low

    function automatic logic ares_iesb_hit(input logic [CTRL_W-1:0] c,
                                           input logic [1:0] lvl,
                                           input int nmeaBit);
        ares_iesb_hit = c[CB_IMPLICIT_SYNC]
            && (c[CB_IESB_LSB + int'(lvl)]
                || (c[CB_DOUBLE_FAULT] && lvl == LVL3 && c[nmeaBit]));
    endfunction : ares_iesb_hit

    logic isErr;
    logic isPrefetch;
    logic addrTaken;
    logic entryHit;
    logic returnHit;
    assign isErr = (reqKind == ARES_ASYNC_SYSTEM_ERROR);
    assign isPrefetch = (reqKind == ARES_PREFETCH_ABORT);
    assign addrTaken = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    // debug level switch and debug return count as entry and return
    assign entryHit = (excEntry || debugLevelSwitch) && !entryNarrow
        && ares_iesb_hit(q.ctrl, entryLevel, CB_NMEA_ENTRY); // [RL12]
    assign returnHit = (excReturn || debugReturn) && !returnNarrow
        && ares_iesb_hit(q.ctrl, returnLevel, CB_NMEA_RETURN); // [RL13]

    // ==================================================
    // next state
    always_comb begin
        next_q = q;
        next_q.routeValid = 1'b0;
        next_q.syncEvent = 1'b0;
        next_q.serrTake = 1'b0;

        // register writes in the data phase
        if (q.dataPhase && q.dataWrite && q.dataMapped) begin
            unique case (q.dataIdx)
                IDX_CTRL: next_q.ctrl = hwdata[CTRL_W-1:0];
                IDX_ROUTE: next_q.route = hwdata[ROUTE_W-1:0];
                IDX_DEFER: begin
                    if (hwdata[DB_VALID]) begin
                        next_q.defValid = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // routing, override order: monitor, hypervisor, default
        if (reqValid) begin
            next_q.routeValid = 1'b1;
            if (!reqNarrow) begin
                next_q.routeMode = ARES_MODE_ABORT;
                next_q.routeOffset = '0;
                if (q.ctrl[CB_EL3_IMPL] && q.route[RB_MON_ROUTE]) begin
                    next_q.routeLevel = LVL3; // [RL3] [RL22]
                end else if (q.ctrl[CB_EL2_IMPL] && q.ctrl[CB_EL2_ENABLED]
                             && ares_low(reqFromLevel) && isErr
                             && (q.route[RB_HYP_ASYNC] || q.route[RB_HYP_GENERAL])) begin
                    next_q.routeLevel = LVL2; // [RL4]
                end else if (q.ctrl[CB_EL2_IMPL] && q.ctrl[CB_EL2_ENABLED]
                             && ares_low(reqFromLevel) && !isErr
                             && (q.route[RB_HYP_EXT_ABORT] || q.route[RB_HYP_GENERAL])) begin
                    next_q.routeLevel = LVL2; // [RL5]
                end else if (ares_low(reqFromLevel)) begin
                    next_q.routeLevel = LVL1; // [RL1]
                end else begin
                    next_q.routeLevel = reqFromLevel; // [RL2]
                end
            end else begin
                if (q.ctrl[CB_EL3_IMPL] && q.route[RB_NMON_ROUTE]) begin
                    next_q.routeMode = ARES_MODE_MONITOR;
                    next_q.routeLevel = LVL3;
                    next_q.routeOffset = isPrefetch ? OFS_PREFETCH : OFS_DATA; // [RL7] [RL8]
                end else if (q.ctrl[CB_EL2_IMPL] && q.ctrl[CB_NON_SECURE]
                             && ares_low(reqFromLevel)
                             && ((isErr && (q.route[RB_NHYP_ASYNC]
                                            || q.route[RB_NHYP_GENERAL]))
                                 || (!isErr && (q.route[RB_NHYP_ABORT]
                                                || q.route[RB_NHYP_GENERAL])))) begin
                    next_q.routeMode = ARES_MODE_HYP;
                    next_q.routeLevel = LVL2;
                    next_q.routeOffset = OFS_HYP; // [RL9] [RL10]
                end else begin
                    // default vector follows the kind of abort
                    next_q.routeMode = (reqFromLevel == LVL2) ? ARES_MODE_HYP
                                                              : ARES_MODE_ABORT; // [RL6]
                    next_q.routeLevel = ares_low(reqFromLevel) ? LVL1 : reqFromLevel;
                    next_q.routeOffset = isPrefetch ? OFS_PREFETCH : OFS_DATA;
                end
            end
        end

        // error synchronization event
        next_q.syncEvent = barrierExec || entryHit || returnHit; // [RL11]
        if (next_q.syncEvent && q.syncPend) begin
            if (!q.ctrl[CB_SERR_MASKED]) begin
                // taken before the event completes, so no later instruction sees it
                next_q.serrTake = 1'b1; // [RL16]
                next_q.syncPend = 1'b0;
            end else if (barrierExec) begin
                next_q.defValid = 1'b1; // [RL14] [RL21]
                next_q.defSyn = q.pendSyn;
                next_q.syncPend = 1'b0;
            end
        end

        // new errors: set wins over any clear above
        if (errRaise) begin
            if (errSameCore) begin
                next_q.syncPend = 1'b1; // [RL15]
                next_q.pendSyn = errSyndrome;
            end else begin
                // foreign errors are never recorded by the barrier
                next_q.otherPend = 1'b1; // [RL15]
            end
        end

        // address phase: read data built from the updated copy, so a read
        // right behind a write sees the written value
        if (addrTaken) begin
            next_q.dataPhase = 1'b1;
            next_q.dataWrite = hwrite;
            next_q.dataMapped = (haddr[ADDR_W-1:MAP_LSB] == '0);
            next_q.dataIdx = haddr[IDX_LSB +: 2];
            next_q.rdata = '0;
            if (!hwrite && next_q.dataMapped) begin
                unique case (next_q.dataIdx)
                    IDX_CTRL: next_q.rdata[CTRL_W-1:0] = next_q.ctrl;
                    IDX_ROUTE: next_q.rdata[ROUTE_W-1:0] = next_q.route;
                    IDX_STAT: begin
                        next_q.rdata[SB_ASYNC] = next_q.syncPend || next_q.otherPend; // [RL18]
                        next_q.rdata[SB_SYNC_PEND] = next_q.syncPend;
                        next_q.rdata[SB_OTHER_PEND] = next_q.otherPend;
                        next_q.rdata[SB_DEF_VALID] = next_q.defValid;
                        next_q.rdata[SB_LEVEL_LSB +: 2] = next_q.routeLevel;
                        next_q.rdata[SB_MODE_LSB +: 2] = next_q.routeMode;
                        next_q.rdata[SB_OFFSET_LSB +: OFS_W] = next_q.routeOffset;
                    end
                    IDX_DEFER: begin
                        next_q.rdata[SYN_W-1:0] = next_q.defSyn;
                        next_q.rdata[DB_VALID] = next_q.defValid;
                    end
                    default: begin
                    end
                endcase
            end
        end else if (hready) begin
            next_q.dataPhase = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{ctrl: CTRL_RESET, route: ROUTE_RESET, routeMode: ARES_MODE_ABORT,
                   default: '0};
        end else begin
            q <= next_q;
        end
    end

    // ==================================================
    // outputs
    // zero wait states: every transfer answers in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign routeValid = q.routeValid;
    assign routeLevel = q.routeLevel;
    assign routeMode = q.routeMode;
    assign routeOffset = q.routeOffset;
    assign syncEvent = q.syncEvent;
    assign serrTake = q.serrTake;
    // pending of either origin shows here; masked barrier clears only the same-core pending
    assign intStatusAsync = q.syncPend || q.otherPend; // [RL17] [RL18] [RL19] [RL20]
    assign deferredValid = q.defValid;

    // ==================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    monitor_override_a: assert property (reqValid && !reqNarrow && q.ctrl[CB_EL3_IMPL] // [RL3]
        && q.route[RB_MON_ROUTE] |=> routeValid && routeLevel == LVL3)
        else $error("monitor routing not taken");
    wide_default_a: assert property (reqValid && !reqNarrow && !q.ctrl[CB_EL3_IMPL] // [RL1]
        && !q.ctrl[CB_EL2_IMPL] && ares_low(reqFromLevel) |=> routeLevel == LVL1)
        else $error("low level default not level 1");
    wide_stay_a: assert property (reqValid && !reqNarrow && !q.ctrl[CB_EL3_IMPL] // [RL2]
        && !ares_low(reqFromLevel) |=> routeLevel == $past(reqFromLevel))
        else $error("high level did not stay");
    hyp_error_a: assert property (reqValid && !reqNarrow && isErr // [RL4]
        && !(q.ctrl[CB_EL3_IMPL] && q.route[RB_MON_ROUTE]) && q.ctrl[CB_EL2_IMPL]
        && q.ctrl[CB_EL2_ENABLED] && ares_low(reqFromLevel) && q.route[RB_HYP_GENERAL]
        |=> routeLevel == LVL2)
        else $error("error not routed to level 2");
    narrow_monitor_a: assert property (reqValid && reqNarrow && q.ctrl[CB_EL3_IMPL] // [RL8]
        && q.route[RB_NMON_ROUTE] |=> routeMode == ARES_MODE_MONITOR
        && routeOffset == ($past(isPrefetch) ? OFS_PREFETCH : OFS_DATA))
        else $error("monitor mode offset wrong");
    narrow_hyp_a: assert property (reqValid && reqNarrow && !q.ctrl[CB_EL3_IMPL] // [RL10]
        && q.ctrl[CB_EL2_IMPL] && q.ctrl[CB_NON_SECURE] && !isErr
        && ares_low(reqFromLevel) && q.route[RB_NHYP_ABORT]
        |=> routeMode == ARES_MODE_HYP && routeOffset == OFS_HYP)
        else $error("hyp offset wrong");
    barrier_event_a: assert property (barrierExec |=> syncEvent) // [RL11]
        else $error("barrier gave no event");
    entry_event_a: assert property ($rose(syncEvent) |-> $past(barrierExec) // [RL12]
        || $past(entryHit) || $past(returnHit))
        else $error("event without cause");
    defer_record_a: assert property (barrierExec && q.syncPend && q.ctrl[CB_SERR_MASKED] // [RL21]
        && !errRaise |=> deferredValid && !q.syncPend && q.defSyn == $past(q.pendSyn))
        else $error("masked error not deferred");
    foreign_keep_a: assert property (q.otherPend && barrierExec |=> q.otherPend // [RL15]
        && intStatusAsync)
        else $error("foreign error dropped");
    // a new error in the take cycle stays pending and may be taken again
    unmasked_take_a: assert property (barrierExec && q.syncPend && !errRaise // [RL16]
        && !q.ctrl[CB_SERR_MASKED] |=> serrTake ##1 !serrTake)
        else $error("unmasked error not taken");

    route_hyp_c: cover property (routeValid && routeMode == ARES_MODE_HYP);
    defer_c: cover property ($rose(deferredValid));
    take_c: cover property (serrTake);
    entry_c: cover property (entryHit ##1 syncEvent);
endmodule : ares_abort_router
`default_nettype wire

// *** verilog/ares_pkg.sv ***
`default_nettype none
package ares_pkg;
    // ==================================================
    // bus and register map
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_ROUTE = 2'h1;
    localparam logic [1:0] IDX_STAT = 2'h2;
    localparam logic [1:0] IDX_DEFER = 2'h3;
    localparam int IDX_LSB = 2;
    localparam int MAP_LSB = 4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // ==================================================
    // control register fields
    localparam int CTRL_W = 14;
    localparam int CB_EL3_IMPL = 0;
    localparam int CB_EL2_IMPL = 1;
    localparam int CB_EL2_ENABLED = 2;
    localparam int CB_NON_SECURE = 3;
    localparam int CB_SERR_MASKED = 4;
    localparam int CB_IMPLICIT_SYNC = 5;
    localparam int CB_DOUBLE_FAULT = 6;
    localparam int CB_IESB_LSB = 8;
    localparam int CB_NMEA_ENTRY = 12;
    localparam int CB_NMEA_RETURN = 13;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;

    // ==================================================
    // routing register fields
    localparam int ROUTE_W = 8;
    localparam int RB_MON_ROUTE = 0;
    localparam int RB_HYP_ASYNC = 1;
    localparam int RB_HYP_GENERAL = 2;
    localparam int RB_HYP_EXT_ABORT = 3;
    localparam int RB_NMON_ROUTE = 4;
    localparam int RB_NHYP_ASYNC = 5;
    localparam int RB_NHYP_GENERAL = 6;
    localparam int RB_NHYP_ABORT = 7;
    localparam logic [ROUTE_W-1:0] ROUTE_RESET = 8'h00;

    // ==================================================
    // status and deferred-error fields
    localparam int SB_ASYNC = 0;
    localparam int SB_SYNC_PEND = 1;
    localparam int SB_OTHER_PEND = 2;
    localparam int SB_DEF_VALID = 3;
    localparam int SB_LEVEL_LSB = 4;
    localparam int SB_MODE_LSB = 6;
    localparam int SB_OFFSET_LSB = 8;
    localparam int SYN_W = 8;
    localparam int DB_VALID = 31;

    // ==================================================
    // levels, kinds, modes, vector offsets
    localparam logic [1:0] LVL0 = 2'h0;
    localparam logic [1:0] LVL1 = 2'h1;
    localparam logic [1:0] LVL2 = 2'h2;
    localparam logic [1:0] LVL3 = 2'h3;
    typedef enum logic [1:0] {
        ARES_ASYNC_SYSTEM_ERROR = 2'h0,
        ARES_DATA_ABORT = 2'h1,
        ARES_PREFETCH_ABORT = 2'h2
    } ares_kind_e;
    typedef enum logic [1:0] {
        ARES_MODE_ABORT = 2'h0,
        ARES_MODE_HYP = 2'h1,
        ARES_MODE_MONITOR = 2'h2
    } ares_mode_e;
    localparam int OFS_W = 5;
    localparam logic [OFS_W-1:0] OFS_DATA = 5'h10;
    localparam logic [OFS_W-1:0] OFS_PREFETCH = 5'h0C;
    localparam logic [OFS_W-1:0] OFS_HYP = 5'h14;
endpackage : ares_pkg
`default_nettype wire
